// *** eeprom_dev_model.sv ***
// Behavioural parallel EEPROM with software write lock.
// Assumes pins come straight from the host; no clock, edge driven.
`timescale 1ns/1ps
module eeprom_dev_model
   import eeprom_lock_pkg::*;
#(
   parameter realtime WIN_NS = 400.0
)(
   input  wire eeprom_lock_pkg::pins_t pins_in,
   output logic                        locked_out,
   output logic [7:0]                  acc_cnt_out,
   output logic [22:0]                 last_out
);
   import eeprom_lock_pkg::*;
   logic [STEP_W-1:0] st_q;
   logic              armed_q;
   realtime           t_fall;
   realtime           t_rise;
   // No reset pin: lock survives host resets
   initial begin
      locked_out = 1'b0;
      acc_cnt_out = 8'h00;
      last_out = 23'h0;
      st_q = 3'h0;
      armed_q = 1'b0;
      t_fall = 0.0;
      t_rise = 0.0;
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic hit;
      hit = (st_q inside {3'h0, 3'h3}) ? (a == CMD_ADDR_A && d == CMD_D_AA) :
            (st_q inside {3'h1, 3'h4}) ? (a == CMD_ADDR_B && d == CMD_D_55) :
            (st_q == 3'h2) ? (a == CMD_ADDR_A && (d == CMD_D_A0 || d == CMD_D_80)) :
            (a == CMD_ADDR_A && d == CMD_D_20);
      if (hit && st_q == 3'h2 && d == CMD_D_A0) begin
         locked_out = 1'b1;
         armed_q = 1'b1;
         st_q = 3'h0;
      end else if (hit && st_q == 3'h5) begin
         locked_out = 1'b0;
         st_q = 3'h0;
      end else if (hit) begin
         st_q = st_q + 3'h1;
      end else begin
         st_q = 3'h0;
         if (!locked_out || armed_q) begin
            acc_cnt_out = acc_cnt_out + 8'h01;
            last_out = {a, d};
         end
      end
   endtask
   // Late fall means the page closed and programming began
   always @(negedge pins_in.we_n) begin
      t_fall = $realtime;
      if (t_fall - t_rise > WIN_NS) begin
         armed_q = 1'b0;
         st_q = 3'h0;
      end
   end
   always @(posedge pins_in.we_n) begin
      if (!pins_in.cs_n && pins_in.oe_n && $realtime - t_fall >= 20.0) begin
         t_rise = $realtime;
         wr(pins_in.addr, pins_in.data);
      end
   end
endmodule // eeprom_dev_model

// *** eeprom_lock_host.sv ***
// Host controller driving a parallel EEPROM with a software write lock.
// Assumes the device pins are wired straight to the outputs; data bus
// is driven only while writing, read path is not used here.
`timescale 1ns/1ps
module eeprom_lock_host
   import eeprom_lock_pkg::*;
#(
   parameter int unsigned LOAD_WIN = LOAD_WIN_CYC
)(
   input  wire logic                     sys_clk_in,
   input  wire logic                     rstn_in,
   input  wire eeprom_lock_pkg::req_t    req_in,
   input  wire logic                     req_valid_in,
   output logic                          req_ready_out,
   output logic                          lock_assumed_out,
   output logic                          prog_wait_out,
   output eeprom_lock_pkg::pins_t        pins_out
);
   import eeprom_lock_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_STROBE = 3'b011,
      ST_HOLD   = 3'b010,
      ST_GAP    = 3'b110
   } state_t;

   state_t            state_q;
   req_t              cur_q;
   logic [STEP_W-1:0] step_q;
   logic [STEP_W-1:0] steps_max;
   logic [CNT_W-1:0]  hold_q;
   logic [CNT_W-1:0]  win_q;
   logic              in_page_q;
   logic              wr_start;
   logic              wr_done;
   logic              we_n;
   logic [ADDR_W-1:0] step_addr;
   logic [DATA_W-1:0] step_data;
   // Step code past every command: the caller's own data byte
   localparam logic [STEP_W-1:0] DATA_STEP = '1;

   // ------------------------------------------------------------
   // Command table
   // ------------------------------------------------------------
   always_comb begin
      steps_max = (cur_q.op == OP_UNLOCK) ? UNLOCK_STEPS :
                  (cur_q.op == OP_LOCK || cur_q.prefix) ? LOCK_STEPS : '0;
      step_addr = CMD_ADDR_A;
      step_data = CMD_D_AA;
      case (step_q)
         3'h0: begin
            step_addr = CMD_ADDR_A;
            step_data = CMD_D_AA;
         end
         3'h1: begin
            step_addr = CMD_ADDR_B;
            step_data = CMD_D_55;
         end
         3'h2: begin
            step_addr = CMD_ADDR_A;
            step_data = (cur_q.op == OP_UNLOCK) ? CMD_D_80 : CMD_D_A0;
         end
         3'h3: begin
            step_addr = CMD_ADDR_A;
            step_data = CMD_D_AA;
         end
         3'h4: begin
            step_addr = CMD_ADDR_B;
            step_data = CMD_D_55;
         end
         3'h5: begin
            step_addr = CMD_ADDR_A;
            step_data = CMD_D_20;
         end
         default: begin
            step_addr = cur_q.addr;
            step_data = cur_q.data;
         end
      endcase
      if (step_q >= steps_max) begin
         step_addr = cur_q.addr;
         step_data = cur_q.data;
      end
   end

   // ------------------------------------------------------------
   // Write sequencer
   // ------------------------------------------------------------
   strobe_cycle u_strobe (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .start_in   (wr_start),
      .we_n_out   (we_n),
      .done_out   (wr_done)
   );

   assign wr_start = (state_q == ST_SETUP);

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         state_q       <= ST_IDLE;
         cur_q         <= '0;
         step_q        <= '0;
         hold_q        <= '0;
         req_ready_out <= 1'b0;
      end else begin
         req_ready_out <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // Take a request only while idle; valid is a level held until ready
               if (req_valid_in && !req_ready_out) begin
                  cur_q   <= req_in;
                  step_q  <= (req_in.op == OP_WRITE && !req_in.prefix) ?
                             DATA_STEP : '0;
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: state_q <= ST_STROBE;
            ST_STROBE: begin
               if (wr_done) begin
                  hold_q  <= CNT_W'(ADDR_HOLD_CYC);
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (hold_q != '0) begin
                  hold_q <= hold_q - 1'b1;
               end else if (step_q != DATA_STEP && step_q + 1'b1 < steps_max) begin
                  step_q  <= step_q + 1'b1;
                  state_q <= ST_SETUP;
               end else if (step_q != DATA_STEP && cur_q.op == OP_WRITE) begin
                  // Data goes straight after the prefix, well inside the window
                  step_q  <= DATA_STEP;
                  state_q <= ST_SETUP;
               end else begin
                  req_ready_out <= 1'b1;
                  state_q       <= ST_GAP;
               end
            end
            ST_GAP: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Byte load window and programming wait
   // ------------------------------------------------------------
   // Strobe rise restarts the window; the last byte of a page must
   // then let it run out so the device begins programming.
   // Timed from the internal strobe, one register ahead of the pin, so the window reloads on the edge the pin rises; prog_wait_out follows a clock later.
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         win_q         <= '0;
         in_page_q     <= 1'b0;
         prog_wait_out <= 1'b0;
      end else begin
         if (we_n && !pins_out.we_n) begin
            win_q     <= CNT_W'(LOAD_WIN);
            in_page_q <= 1'b1;
         end else if (win_q != '0) begin
            win_q <= win_q - 1'b1;
         end else begin
            in_page_q <= 1'b0;
         end
         prog_wait_out <= in_page_q;
      end
   end

   // ------------------------------------------------------------
   // Lock bookkeeping
   // ------------------------------------------------------------
   // Only a guess of the device state: the real lock is nonvolatile
   // and survives our reset, so unknown at start means assume clear.
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         lock_assumed_out <= 1'b0;
      end else if (state_q == ST_HOLD && hold_q == '0) begin
         // A prefixed write arms the lock in the part just as a lock does
         if ((cur_q.op == OP_LOCK || (cur_q.op == OP_WRITE && cur_q.prefix)) &&
             step_q == LOCK_STEPS - 1'b1) begin
            lock_assumed_out <= 1'b1;
         end else if (cur_q.op == OP_UNLOCK && step_q == UNLOCK_STEPS - 1'b1) begin
            lock_assumed_out <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         pins_out <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                       addr: '0, data: '0, data_oe: 1'b0};
      end else begin
         pins_out.oe_n    <= 1'b1;
         pins_out.cs_n    <= !(state_q inside {ST_SETUP, ST_STROBE, ST_HOLD});
         pins_out.we_n    <= we_n;
         pins_out.data_oe <= (state_q inside {ST_SETUP, ST_STROBE, ST_HOLD});
         if (state_q == ST_SETUP) begin
            pins_out.addr <= step_addr;
            pins_out.data <= step_data;
         end
      end
   end
endmodule // eeprom_lock_host

// *** eeprom_lock_host_monitor.sv ***
// Pin checker for the EEPROM write-lock host.
// Assumes it is bound onto eeprom_lock_host; one clock domain.
`timescale 1ns/1ps
module eeprom_lock_host_monitor
   import eeprom_lock_pkg::*;
#(
   parameter int unsigned LOAD_WIN = LOAD_WIN_CYC
)(
   input wire logic                   sys_clk_in,
   input wire logic                   rstn_in,
   input wire eeprom_lock_pkg::req_t  req_in,
   input wire logic                   req_valid_in,
   input wire logic                   req_ready_out,
   input wire logic                   lock_assumed_out,
   input wire logic                   prog_wait_out,
   input wire eeprom_lock_pkg::pins_t pins_out
);
   import eeprom_lock_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   // ----------------------------------------
   // Strobe shape, output gate, ready pulse and load window start
   // ----------------------------------------
   sequence strobe_low_s; (!pins_out.we_n) [*8]; endsequence
   sequence strobe_high_s; pins_out.we_n [*8]; endsequence
   gate_high_a: assert property (pins_out.oe_n)
      else $error("output gate low");
   write_select_a: assert property (!pins_out.we_n |-> !pins_out.cs_n && pins_out.data_oe)
      else $error("strobe low without select or data drive");
   strobe_width_a: assert property ($fell(pins_out.we_n) |-> strobe_low_s)
      else $error("strobe pulse too short");
   strobe_gap_a: assert property ($rose(pins_out.we_n) |-> strobe_high_s)
      else $error("strobe high time too short");
   latch_stable_a: assert property (!pins_out.we_n |=> pins_out.we_n ||
      ($stable(pins_out.addr) && $stable(pins_out.data)))
      else $error("address or data moved under strobe");
   ready_idle_a: assert property (req_ready_out |-> pins_out.we_n ##1 !req_ready_out)
      else $error("ready not a single idle pulse");
   window_start_a: assert property ($rose(pins_out.we_n) |-> ##[0:4] prog_wait_out)
      else $error("load window not started");
   // ----------------------------------------
   // Lock belief follows command bytes
   // ----------------------------------------
   lock_cmd_a: assert property ($rose(lock_assumed_out) |->
      pins_out.addr == CMD_ADDR_A && pins_out.data == CMD_D_A0)
      else $error("lock belief set without third lock byte");
   unlock_cmd_a: assert property ($fell(lock_assumed_out) |->
      pins_out.addr == CMD_ADDR_A && pins_out.data == CMD_D_20)
      else $error("lock belief cleared without sixth unlock byte");
endmodule // eeprom_lock_host_monitor

bind eeprom_lock_host eeprom_lock_host_monitor #(.LOAD_WIN(LOAD_WIN)) u_mon (
   .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .req_in(req_in),
   .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
   .lock_assumed_out(lock_assumed_out), .prog_wait_out(prog_wait_out),
   .pins_out(pins_out));

// *** eeprom_lock_pkg.sv ***
// Package for the parallel EEPROM write-lock host sequencer.
// Assumes a 125 MHz system clock; all pin timing is derived from it.
package eeprom_lock_pkg;
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned ADDR_W         = 15;
   localparam int unsigned DATA_W         = 8;
   // Strobe pulse width, least, in ns; must clear the 20 ns glitch filter
   localparam int unsigned STROBE_LOW_NS  = 150;
   localparam int unsigned STROBE_HIGH_NS = 150;
   localparam int unsigned ADDR_HOLD_NS   = 100;
   // Byte load window, longest, in us
   localparam int unsigned LOAD_WIN_US    = 100;
   localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ADDR_HOLD_CYC   = (ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned LOAD_WIN_CYC    = LOAD_WIN_US * CLK_MHZ;
   localparam int unsigned CNT_W           = 16;
   localparam int unsigned STEP_W          = 3;
   // Command words
   localparam logic [ADDR_W-1:0] CMD_ADDR_A = 15'h5555;
   localparam logic [ADDR_W-1:0] CMD_ADDR_B = 15'h2AAA;
   localparam logic [DATA_W-1:0] CMD_D_AA   = 8'hAA;
   localparam logic [DATA_W-1:0] CMD_D_55   = 8'h55;
   localparam logic [DATA_W-1:0] CMD_D_A0   = 8'hA0;
   localparam logic [DATA_W-1:0] CMD_D_80   = 8'h80;
   localparam logic [DATA_W-1:0] CMD_D_20   = 8'h20;
   localparam logic [STEP_W-1:0] LOCK_STEPS   = 3'h3;
   localparam logic [STEP_W-1:0] UNLOCK_STEPS = 3'h6;

   typedef enum logic [1:0] {
      OP_WRITE  = 2'h0,
      OP_LOCK   = 2'h1,
      OP_UNLOCK = 2'h2
   } op_t;

   typedef struct packed {
      op_t               op;
      logic              prefix;
      logic              last;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } req_t;

   typedef struct packed {
      logic              cs_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic              data_oe;
   } pins_t;
endpackage

// *** strobe_cycle.sv ***
// One bus write cycle on the EEPROM pins: strobe low, strobe high.
// Assumes the caller keeps address and data steady while busy.
`timescale 1ns/1ps
module strobe_cycle
   import eeprom_lock_pkg::*;
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  rstn_in,
   input  wire logic                  start_in,
   output logic                       we_n_out,
   output logic                       done_out
);
   import eeprom_lock_pkg::*;
   logic [CNT_W-1:0] cnt_q;
   logic             low_q;
   logic             busy_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cnt_q    <= '0;
         low_q    <= 1'b0;
         busy_q   <= 1'b0;
         we_n_out <= 1'b1;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (!busy_q && start_in) begin
            busy_q   <= 1'b1;
            low_q    <= 1'b1;
            we_n_out <= 1'b0;
            cnt_q    <= CNT_W'(STROBE_LOW_CYC - 1);
         end else if (busy_q) begin
            if (cnt_q != '0) begin
               cnt_q <= cnt_q - 1'b1;
            end else if (low_q) begin
               // Rising edge latches data; high time then hold
               low_q    <= 1'b0;
               we_n_out <= 1'b1;
               cnt_q    <= CNT_W'(STROBE_HIGH_CYC - 1);
            end else begin
               busy_q   <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end
endmodule // strobe_cycle

// *** tb.sv ***
// Self-checking bench for the EEPROM write-lock host.
// Assumes the device model stands on the pins; short load window.
`timescale 1ns/1ps
module tb;
   import eeprom_lock_pkg::*;
   localparam int unsigned WIN = 50;
   logic        sys_clk_in;
   logic        rstn_in = 1'b0;
   logic        req_valid_in = 1'b0;
   req_t        req_in = '0;
   logic        req_ready_out;
   logic        lock_assumed_out;
   logic        prog_wait_out;
   pins_t       pins_out;
   logic        dev_locked;
   logic [7:0]  acc_cnt;
   logic [22:0] last_wr;
   int          bad_count = 0;
   int          samples_checked = 0;
   eeprom_lock_host #(.LOAD_WIN(WIN)) u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .req_in(req_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
      .lock_assumed_out(lock_assumed_out), .prog_wait_out(prog_wait_out),
      .pins_out(pins_out));
   eeprom_dev_model #(.WIN_NS(WIN * 8.0)) u_dev (.pins_in(pins_out),
      .locked_out(dev_locked), .acc_cnt_out(acc_cnt), .last_out(last_wr));
   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge sys_clk_in);
   endtask
   task automatic reset_dut();
      rstn_in <= 1'b0;
      idle(3);
      rstn_in <= 1'b1;
      idle(1);
   endtask
   // Request held steady until ready; next one three cycles on
   task automatic send(input op_t op, input logic pf, input logic [14:0] a,
                       input logic [7:0] d);
      int n;
      @(posedge sys_clk_in);
      req_in <= '{op: op, prefix: pf, last: 1'b1, addr: a, data: d};
      req_valid_in <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (req_ready_out !== 1'b1 && n < 2000);
      req_valid_in <= 1'b0;
      if (n >= 2000) begin
         bad_count++;
         stop_test();
      end else begin
         idle(2);
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_plain_unlocked();
      send(OP_WRITE, 1'b0, 15'h0123, 8'h5A);
      chk(acc_cnt, 32'h1);
      chk(last_wr, {15'h0123, 8'h5A});
      chk(prog_wait_out, 32'h1);
      idle(2 * WIN);
      chk(prog_wait_out, 32'h0);
   endtask
   task automatic t_lock_prefixed();
      send(OP_LOCK, 1'b0, 15'h0000, 8'h00);
      chk(dev_locked, 32'h1);
      chk(lock_assumed_out, 32'h1);
      idle(2 * WIN);
      send(OP_WRITE, 1'b1, 15'h0240, 8'hC3);
      chk(acc_cnt, 32'h2);
      chk(last_wr, {15'h0240, 8'hC3});
   endtask
   task automatic t_unlock_plain();
      send(OP_UNLOCK, 1'b0, 15'h0000, 8'h00);
      chk(dev_locked, 32'h0);
      chk(lock_assumed_out, 32'h0);
      idle(2 * WIN);
      send(OP_WRITE, 1'b0, 15'h7FFF, 8'h3C);
      chk(acc_cnt, 32'h3);
   endtask
   // Host reset stands in for a power cycle of the system
   task automatic t_lock_survives();
      send(OP_LOCK, 1'b0, 15'h0000, 8'h00);
      reset_dut();
      chk(dev_locked, 32'h1);
      chk(lock_assumed_out, 32'h0);
   endtask
   initial begin
      reset_dut();
      t_plain_unlocked();
      t_lock_prefixed();
      t_unlock_plain();
      t_lock_survives();
      stop_test();
   end
endmodule // tb
